// ### host_port_pkg.sv
// Package: constants for the host data port front end
package host_port_pkg;
    localparam int BUS_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int SER_DATA_BIT = 7;
    localparam int SER_CLK_BIT = 6;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int BUF_DEPTH = 2;
endpackage : host_port_pkg

// ### byte_buffer.sv
// Two-entry buffer carrying a byte and its data/instruction flag
`timescale 1ns/1ps
module byte_buffer
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [host_port_pkg::BUS_W:0] in_word_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [host_port_pkg::BUS_W:0] out_word_out
);
    import host_port_pkg::*;
    logic [BUS_W:0] mem_r [BUF_DEPTH];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;
    wire push = in_valid_in && (count_r != 2'h2);
    wire pop = out_valid_out && out_ready_in;

    assign in_ready_out = (count_r != 2'h2);
    assign out_valid_out = (count_r != 2'h0);
    assign out_word_out = mem_r[rd_ptr_r];

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                mem_r[wr_ptr_r] <= in_word_in;
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end

    no_overfill_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        count_r <= 2'h2)
        else $error("buffer count overflow");
endmodule : byte_buffer

// ### host_data_port_front_end.sv
// Top: parallel or serial host byte intake front end
`timescale 1ns/1ps
// What this block does
// - With the interface select high the eight data pins form a tri-state parallel bus driven only on reads.
// - With the interface select low the top data pin is the serial data input.
// - With the interface select low data pin six is the serial shift clock.
// - In serial mode one bit is sampled on each rising shift clock edge.
// - On the eighth rising shift clock edge the bits become a parallel byte.
// - In parallel mode the bus byte is captured at the rising edge of the write strobe.
// - In parallel mode the bus is driven only while the read strobe is low.
module host_data_port_front_end
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Mode strap
    input wire logic parallel_sel_in,
    // Host pins
    input wire logic cs_n_in,
    input wire logic data_instruction_select_in,
    input wire logic wr_n_in,
    input wire logic rd_n_in,
    input wire logic [host_port_pkg::BUS_W-1:0] host_data_bus_in,
    output logic [host_port_pkg::BUS_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe_out,
    // Read data from the core
    input wire logic [host_port_pkg::BUS_W-1:0] read_byte_in,
    // Byte stream to the core
    output logic byte_valid_out,
    input wire logic byte_ready_in,
    output logic [host_port_pkg::BUS_W-1:0] byte_out,
    output logic byte_is_data_out
);
    import host_port_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    // Rising edge of a pin against its level at the last clock
    function automatic logic rose_edge(input logic now_lvl,
        input logic last_lvl);
        return now_lvl && !last_lvl;
    endfunction : rose_edge

    // ****************************************
    // Edge detection
    // ****************************************
    logic wr_n_d_r;
    logic scl_d_r;
    logic [BIT_CNT_W-1:0] bit_cnt_r;
    logic [BUS_W-1:0] shift_r;
    logic [BUS_W-1:0] rd_data_r;
    logic oe_r;
    logic buf_valid;
    logic buf_ready;
    logic [BUS_W:0] buf_word;

    wire scl = host_data_bus_in[SER_CLK_BIT];
    wire sdi = host_data_bus_in[SER_DATA_BIT];
    wire scl_rise = !parallel_sel_in && !cs_n_in &&
        rose_edge(scl, scl_d_r);
    wire wr_rise = parallel_sel_in && !cs_n_in &&
        rose_edge(wr_n_in, wr_n_d_r);
    wire ser_done = scl_rise && (bit_cnt_r == LAST_BIT);
    wire [BUS_W-1:0] ser_byte = {shift_r[BUS_W-2:0], sdi};
    wire push = wr_rise || ser_done;
    // Byte plus select bit taken together at the capture edge
    wire [BUS_W:0] push_word = {data_instruction_select_in,
        wr_rise ? host_data_bus_in : ser_byte};
    wire drive = parallel_sel_in && !cs_n_in && !rd_n_in;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            wr_n_d_r <= 1'b1;
            scl_d_r <= 1'b0;
        end
        else
        begin
            wr_n_d_r <= wr_n_in;
            scl_d_r <= scl;
        end
    end

    // ****************************************
    // Serial shifter
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (srst_in || parallel_sel_in || cs_n_in)
        begin
            bit_cnt_r <= '0;
            shift_r <= BYTE_RESET;
        end
        else if (scl_rise)
        begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r <= ser_byte;
        end
    end

    // ****************************************
    // Read drive
    // ****************************************
    // Bus driven only in parallel mode during a read strobe
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            oe_r <= 1'b0;
            rd_data_r <= BYTE_RESET;
        end
        else
        begin
            oe_r <= drive;
            rd_data_r <= read_byte_in;
        end
    end
    assign host_data_bus_oe_out = oe_r;
    assign host_data_bus_out = rd_data_r;

    // ****************************************
    // Output buffer
    // ****************************************
    // Host strobes cannot be stalled; a full buffer drops the byte
    byte_buffer u_buf
    (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .in_valid_in(push),
        .in_ready_out(),
        .in_word_in(push_word),
        .out_valid_out(buf_valid),
        .out_ready_in(buf_ready),
        .out_word_out(buf_word)
    );

    logic valid_r;
    logic [BUS_W:0] word_r;
    assign buf_ready = !valid_r || byte_ready_in;
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            valid_r <= 1'b0;
        else if (buf_ready)
        begin
            valid_r <= buf_valid;
            word_r <= buf_word;
        end
    end
    assign byte_valid_out = valid_r;
    assign byte_out = word_r[BUS_W-1:0];
    assign byte_is_data_out = word_r[BUS_W];

    // ****************************************
    // Checks
    // ****************************************
    oe_par_only_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        host_data_bus_oe_out |-> $past(parallel_sel_in))
        else $error("bus driven outside parallel mode");
    oe_rd_low_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        host_data_bus_oe_out |-> $past(!rd_n_in && !cs_n_in))
        else $error("bus driven without read strobe");
    oe_follows_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        drive |=> host_data_bus_oe_out)
        else $error("read strobe not answered");
    ser_eighth_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        ser_done |=> bit_cnt_r == '0)
        else $error("serial count not restarted after eighth edge");
    ser_count_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (scl_rise && bit_cnt_r != LAST_BIT) |=>
        bit_cnt_r == $past(bit_cnt_r) + 3'h1)
        else $error("serial bit count stuck");
    ser_sample_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        scl_rise |=> shift_r[0] == $past(host_data_bus_in[SER_DATA_BIT]))
        else $error("serial bit not sampled");
    wr_capture_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_rise |-> push_word[BUS_W-1:0] == host_data_bus_in)
        else $error("write byte not captured");
    sel_carry_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        push |-> push_word[BUS_W] == data_instruction_select_in)
        else $error("select bit lost");
    scl_pin_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !parallel_sel_in |=> scl_d_r == $past(host_data_bus_in[SER_CLK_BIT]))
        else $error("shift clock not taken from pin six");
    stall_hold_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (byte_valid_out && !byte_ready_in) |=> byte_valid_out &&
        $stable(byte_out) && $stable(byte_is_data_out))
        else $error("stalled byte changed");
    rd_data_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        host_data_bus_oe_out |-> host_data_bus_out == $past(read_byte_in))
        else $error("read data not from core byte");
    oe_release_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !drive |=> !host_data_bus_oe_out)
        else $error("bus held after read strobe");
    ser_idle_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (parallel_sel_in || cs_n_in) |=> bit_cnt_r == '0)
        else $error("partial serial byte kept");
    oe_serial_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !parallel_sel_in |=> !host_data_bus_oe_out)
        else $error("bus driven in serial mode");
    oe_cs_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        cs_n_in |=> !host_data_bus_oe_out)
        else $error("bus driven while deselected");
    cov_wr: cover property (@(posedge clk_in) wr_rise);
    cov_instr: cover property (@(posedge clk_in)
        push && !data_instruction_select_in);
    cov_ser: cover property (@(posedge clk_in) ser_done);
    cov_rd: cover property (@(posedge clk_in) host_data_bus_oe_out);
    cov_stall: cover property (@(posedge clk_in) valid_r && !byte_ready_in);
endmodule : host_data_port_front_end

// ### host_model.sv
// Host model driving write, serial and read cycles
`timescale 1ns/1ps
module host_model
(
    // Clock and device drive
    input wire logic clk_in,
    input wire logic oe_in,
    input wire logic [7:0] dev_in,
    // Host pins
    output logic [7:0] pin_out,
    output logic cs_n_out,
    output logic dis_out,
    output logic wr_n_out,
    output logic rd_n_out
);
    logic [7:0] drv_r;
    initial
    begin
        drv_r = 8'h00;
        cs_n_out = 1'b1;
        dis_out = 1'b0;
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
    end
    // Device wins the wire only while it drives
    assign pin_out = oe_in ? dev_in : drv_r;
    task wr(input logic [7:0] b, input logic d);
        cs_n_out = 1'b0;
        dis_out = d;
        drv_r = b;
        wr_n_out = 1'b0;
        @(negedge clk_in);
        wr_n_out = 1'b1;
        repeat (2) @(negedge clk_in);
        cs_n_out = 1'b1;
        @(negedge clk_in);
    endtask : wr
    task ser(input logic [7:0] b, input logic d);
        cs_n_out = 1'b0;
        dis_out = d;
        for (int i = 7; i >= 0; i--)
        begin
            drv_r = {b[i], 7'h00};
            @(negedge clk_in);
            drv_r[6] = 1'b1;
            @(negedge clk_in);
        end
        cs_n_out = 1'b1;
        @(negedge clk_in);
    endtask : ser
    task rd(output logic [7:0] v);
        cs_n_out = 1'b0;
        rd_n_out = 1'b0;
        repeat (3) @(negedge clk_in);
        v = pin_out;
        rd_n_out = 1'b1;
        repeat (2) @(negedge clk_in);
        cs_n_out = 1'b1;
    endtask : rd
endmodule : host_model

// ### host_data_port_front_end_bench.sv
// Bench for the host data port front end
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
$display("wrong value t=%0t got=%h exp=%h", $time, a, e); end end
module host_data_port_front_end_bench;
    import host_port_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel = 1'b1;
    logic rdy = 1'b0;
    logic [7:0] rbyte = 8'h5a;
    logic [7:0] v;
    wire [7:0] dout, pin, bout;
    wire oe, cs_n, dis, wr_n, rd_n, bval, bdat;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    initial forever #4 clk_in = ~clk_in;
    host_model host (.clk_in(clk_in), .oe_in(oe), .dev_in(dout),
        .pin_out(pin), .cs_n_out(cs_n), .dis_out(dis), .wr_n_out(wr_n),
        .rd_n_out(rd_n));
    host_data_port_front_end dut (.clk_in(clk_in), .srst_in(srst_in),
        .parallel_sel_in(psel), .cs_n_in(cs_n),
        .data_instruction_select_in(dis), .wr_n_in(wr_n), .rd_n_in(rd_n),
        .host_data_bus_in(pin), .host_data_bus_out(dout),
        .host_data_bus_oe_out(oe), .read_byte_in(rbyte),
        .byte_valid_out(bval), .byte_ready_in(rdy), .byte_out(bout),
        .byte_is_data_out(bdat));
    task stop_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // Hang guard
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc > 4000)
        begin
            err_total++;
            stop_test;
        end
    end
    task got(input logic [7:0] b, input logic d);
        int n;
        for (n = 0; n < 30 && bval !== 1'b1; n++)
            @(negedge clk_in);
        `CHK(bval, 1'b1)
        `CHK(bout, b)
        `CHK(bdat, d)
        rdy = 1'b1;
        @(negedge clk_in);
        rdy = 1'b0;
    endtask : got
    task t_par;
        host.wr(8'ha5, 1'b1);
        got(8'ha5, 1'b1);
        host.wr(8'h3c, 1'b0);
        got(8'h3c, 1'b0);
    endtask : t_par
    task t_ser;
        psel = 1'b0;
        host.ser(8'hc3, 1'b0);
        got(8'hc3, 1'b0);
        host.ser(8'h81, 1'b1);
        got(8'h81, 1'b1);
        psel = 1'b1;
    endtask : t_ser
    task t_rd;
        host.rd(v);
        `CHK(v, 8'h5a)
        `CHK(oe, 1'b0)
        psel = 1'b0;
        host.rd(v);
        `CHK(v === 8'h5a, 1'b0)
        psel = 1'b1;
    endtask : t_rd
    // Stall: two entries plus output stage hold, the next is dropped
    task t_stall;
        host.wr(8'h11, 1'b1);
        host.wr(8'h22, 1'b0);
        host.wr(8'h33, 1'b1);
        host.wr(8'h44, 1'b0);
        got(8'h11, 1'b1);
        got(8'h22, 1'b0);
        got(8'h33, 1'b1);
        repeat (3) @(negedge clk_in);
        `CHK(bval, 1'b0)
    endtask : t_stall
    initial
    begin
        repeat (5) @(negedge clk_in);
        srst_in = 1'b0;
        @(negedge clk_in);
        t_par;
        t_ser;
        t_rd;
        t_stall;
        stop_test;
    end
endmodule : host_data_port_front_end_bench
